// >>> hdl/lcd_host_pkg.sv
/*
  Shared constants for the LCD host port: bus modes, command codes,
  reset values, memory shape and host strobe timing.
  Assumes both ends, the bus checker and the bench import it.
*/
package lcd_host_pkg;
  // ------------------------------------------------------------
  // Bus modes (strap level on the mode pins)
  // ------------------------------------------------------------
  localparam logic [1:0] MODE_6800 = 2'h0;
  localparam logic [1:0] MODE_8080 = 2'h1;
  localparam logic [1:0] MODE_SERIAL = 2'h2;
  // Serial link lines on the data bus
  localparam int SCLK_BIT = 6;
  localparam int SDATA_BIT = 7;
  // ------------------------------------------------------------
  // Display memory shape
  // ------------------------------------------------------------
  localparam int RAM_COLS = 132;
  localparam int RAM_PAGES = 9;
  localparam int RAM_WORDS = RAM_COLS * RAM_PAGES;
  localparam logic [7:0] LAST_COL = 8'h83;
  localparam logic [6:0] MUX_RATIO_RST = 7'h40;
  // ------------------------------------------------------------
  // Command codes (prefix fields and full bytes)
  // ------------------------------------------------------------
  localparam logic [3:0] CMD_COL_LO = 4'h0;
  localparam logic [3:0] CMD_COL_HI = 4'h1;
  localparam logic [4:0] CMD_RATIO = 5'h04;
  localparam logic [4:0] CMD_POWER = 5'h05;
  localparam logic [1:0] CMD_START = 2'h1;
  localparam logic [3:0] CMD_PAGE = 4'hB;
  localparam logic [7:0] CMD_SEG_NORM = 8'hA0;
  localparam logic [7:0] CMD_SEG_REV = 8'hA1;
  localparam logic [7:0] CMD_ROW_NORM = 8'hC0;
  localparam logic [7:0] CMD_ROW_REV = 8'hC8;
  localparam logic [7:0] CMD_CONTRAST = 8'h81;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [5:0] CONTRAST_RST = 6'h20;
  localparam logic [2:0] RATIO_RST = 3'h4;
  localparam logic [2:0] POWER_RST = 3'h0;
  localparam logic [5:0] START_RST = 6'h00;
  // Host timing: ref_clk cycles per strobe phase
  localparam logic [7:0] HOST_DIV = 8'h08;
  // Item carried by the write FIFO: select bit over data byte
  localparam int ITEM_W = 9;
  // Pin bundle as sampled by the device
  typedef struct packed {
    logic [1:0] mode;
    logic data_select;
    logic rw_strobe;
    logic rd_strobe;
    logic chip_select_active_high;
    logic chip_select_active_low;
    logic [7:0] d;
  } pins_type;
endpackage : lcd_host_pkg

// >>> hdl/lcd_bus_if.sv
/*
  Pin-level link between host end and display end.
  Assumes the bench joins both ends; the data wire is resolved here.
*/
`timescale 1ns/1ns
`default_nettype none
interface lcd_bus_if;
  logic [1:0] mode; // Bus mode strap
  logic data_select; // High: display data, low: command
  logic rw_strobe; // R/W in 6800, write strobe in 8080
  logic rd_strobe; // Enable in 6800, read strobe in 8080
  logic chip_select_active_low; // Selected when low
  logic chip_select_active_high; // Selected when high
  logic [7:0] host_d_out; // Host data drive
  logic host_d_oe_n; // Host drives when low
  logic [7:0] dev_d_out; // Device data drive
  logic dev_d_oe_n; // Device drives when low
  logic [7:0] d; // Resolved bus, pulled up when idle
  // Wire resolution, pull-up when nobody drives
  assign d = !host_d_oe_n ? host_d_out : (!dev_d_oe_n ? dev_d_out : 8'hFF);
  modport host (output mode, data_select, rw_strobe, rd_strobe,
    chip_select_active_low, chip_select_active_high, host_d_out, host_d_oe_n,
    input d);
  modport dev (input mode, data_select, rw_strobe, rd_strobe,
    chip_select_active_low, chip_select_active_high, d,
    output dev_d_out, dev_d_oe_n);
endinterface : lcd_bus_if
`default_nettype wire

// >>> hdl/lcd_device_end.sv
/*
  Display end: pin front end (6800, 8080, serial), write FIFO,
  command decoder, display memory and scan address mapping.
  Assumes pins arrive unsynchronised and ref_clk is far faster than strobes.
*/
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Write FIFO
// ------------------------------------------------------------
module item_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_state_type;
  fifo_state_type s, next_s;
  logic [WIDTH-1:0] mem [DEPTH]; // Storage words
  logic push, pop;
  // Honest flags from the fill count
  assign in_ready = s.cnt != (AW+1)'(DEPTH);
  assign out_valid = s.cnt != '0;
  assign out_data = mem[s.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // Pointer and count update
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.wp = (s.wp == AW'(DEPTH-1)) ? '0 : s.wp + AW'(1);
    end
    if (pop) begin
      next_s.rp = (s.rp == AW'(DEPTH-1)) ? '0 : s.rp + AW'(1);
    end
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  // Register state; storage needs no reset
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
    if (push) begin
      mem[s.wp] <= in_data;
    end
  end
endmodule : item_fifo

// How it works
// - Select high stores byte into display memory
// - Select low decodes byte as command
// - Parallel modes: eight data lines plus controls
// - 6800 direction high reads data or status
// - 6800 direction low writes data or command
// - 6800 enable high strobes while selected
// - Host discards dummy read first (6800)
// - 8080 read strobe active low while selected
// - 8080 read: select picks data or status
// - 8080 write strobe latches at high
// - 8080 write: select picks data or command
// - Host discards dummy read first (8080)
// - Serial: line 6 clock, line 7 data
// - Shift eight bits MSB first on rise
// - Eighth clock samples select, commits byte
// - Memory is 132 by 65 bits; here 9 full pages are stored, 132 by 72 bits
// - Start line register scrolls display vertically
// - Column and row mapping reversible independently
// - Rows beyond mux range are non-select
// - Contrast has 64 software levels
// - Eight resistor ratios when internal feedback
// - Reset clears serial shift register
// - Start line six bits, reset zero
module lcd_device_end
  import lcd_host_pkg::*;
#(
  parameter logic [6:0] MUX_RATIO = MUX_RATIO_RST
) (
  input wire logic ref_clk,
  input wire logic srst,
  lcd_bus_if.dev bus,
  input wire logic regulator_source_select,
  input wire logic [6:0] scan_row,
  input wire logic [7:0] scan_col,
  output logic [5:0] start_line,
  output logic seg_remap,
  output logic row_remap,
  output logic [5:0] contrast,
  output logic [2:0] ratio,
  output logic internal_feedback,
  output logic [2:0] power_ctrl,
  output logic [6:0] row_driver_output,
  output logic row_non_select,
  output logic [7:0] scan_byte
);
  typedef struct packed {
    pins_type meta; // First sync stage
    pins_type sync; // Second sync stage
    pins_type prev; // Edge reference
    logic [7:0] shift; // Serial shift register
    logic [2:0] bitcnt; // Serial bit count
    logic pend_valid; // Byte waiting for FIFO room
    logic [ITEM_W-1:0] pend;
    logic arg_contrast; // Next command byte is contrast
    logic [7:0] col;
    logic [3:0] page;
    logic [5:0] start;
    logic seg_rev;
    logic row_rev;
    logic [5:0] contrast;
    logic [2:0] ratio;
    logic [2:0] power;
    logic fb_meta; // Strap, first sync stage
    logic int_fb;
    logic rd_wait; // Read pipeline refill cycle
    logic [7:0] rd_latch; // Pipelined read data
    logic [7:0] dout;
    logic doe_n;
    logic [6:0] row_line;
    logic non_sel;
  } dev_state_type;
  dev_state_type s, next_s;
  logic [7:0] ram [RAM_WORDS]; // Display memory, page-major
  logic [7:0] ram_q; // Read port for host reads
  logic [7:0] scan_q; // Read port for the scan
  logic [10:0] ram_addr, scan_addr;
  logic ram_we;
  pins_type pins;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [ITEM_W-1:0] fifo_out_data;
  // ------------------------------------------------------------
  // Pin bundle and FIFO
  // ------------------------------------------------------------
  assign pins = '{bus.mode, bus.data_select, bus.rw_strobe, bus.rd_strobe,
    bus.chip_select_active_high, bus.chip_select_active_low, bus.d};
  // Drain stalls during a read refill so the memory port is free
  assign fifo_out_ready = !s.rd_wait;
  assign ram_we = fifo_out_valid && fifo_out_ready && fifo_out_data[8];
  item_fifo #(.WIDTH(ITEM_W), .DEPTH(8)) u_fifo (
    .ref_clk(ref_clk),
    .srst(srst),
    .in_valid(s.pend_valid),
    .in_ready(fifo_in_ready),
    .in_data(s.pend),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );
  // ------------------------------------------------------------
  // Main next-state logic
  // ------------------------------------------------------------
  always_comb begin
    logic sel, selq, rd_act, wr_end, rd_end, sck_rise;
    logic [7:0] cmd, sbyte;
    logic [6:0] idx;
    next_s = s;
    sel = 1'b0;
    selq = 1'b0;
    rd_act = 1'b0;
    wr_end = 1'b0;
    rd_end = 1'b0;
    sck_rise = 1'b0;
    cmd = fifo_out_data[7:0];
    sbyte = {s.shift[6:0], s.sync.d[SDATA_BIT]};
    idx = 7'h00;
    next_s.meta = pins;
    next_s.sync = s.meta;
    next_s.prev = s.sync;
    // Selected only with low and high selects both met
    sel = !s.sync.chip_select_active_low && s.sync.chip_select_active_high;
    selq = !s.prev.chip_select_active_low && s.prev.chip_select_active_high;
    // Strobe decode per mode
    unique case (s.sync.mode)
      MODE_6800: begin
        rd_act = sel && s.sync.rd_strobe && s.sync.rw_strobe;
        wr_end = selq && s.prev.rd_strobe && !s.sync.rd_strobe && !s.prev.rw_strobe;
        rd_end = selq && s.prev.rd_strobe && !s.sync.rd_strobe && s.prev.rw_strobe;
      end
      MODE_8080: begin
        rd_act = sel && !s.sync.rd_strobe;
        rd_end = selq && !s.prev.rd_strobe && s.sync.rd_strobe;
        wr_end = selq && !s.prev.rw_strobe && s.sync.rw_strobe;
      end
      MODE_SERIAL: begin
        // Clock on line 6 gated by selects
        sck_rise = sel && !s.prev.d[SCLK_BIT] && s.sync.d[SCLK_BIT];
      end
      default: begin
        rd_act = 1'b0;
      end
    endcase
    // FIFO takes the pending byte; a new byte in the same cycle wins
    if (s.pend_valid && fifo_in_ready) begin
      next_s.pend_valid = 1'b0;
    end
    // Parallel write: eight lines with select bit
    if (wr_end) begin
      next_s.pend_valid = 1'b1;
      next_s.pend = {s.prev.data_select, s.prev.d};
    end
    // Serial shift, MSB first
    if (sck_rise) begin
      next_s.shift = sbyte;
      next_s.bitcnt = s.bitcnt + 3'h1;
      if (s.bitcnt == 3'h7) begin
        // Eighth clock: sample select, commit byte
        next_s.pend_valid = 1'b1;
        next_s.pend = {s.sync.data_select, sbyte};
      end
    end
    // Read drive: data latch or status, released when not reading
    next_s.doe_n = !rd_act;
    next_s.dout = s.sync.data_select ? s.rd_latch
      : {fifo_out_valid, s.seg_rev, s.row_rev, s.int_fb, 4'h0};
    // Data read end refills the pipeline: first read gives stale byte
    if (rd_end && s.prev.data_select) begin
      next_s.rd_wait = 1'b1;
    end
    if (s.rd_wait) begin
      next_s.rd_wait = 1'b0;
      next_s.rd_latch = ram_q;
      next_s.col = (s.col == LAST_COL) ? s.col : s.col + 8'h01;
    end
    // Drain one item per free cycle
    if (fifo_out_valid && fifo_out_ready) begin
      if (fifo_out_data[8]) begin
        // Data byte written below, column advances
        next_s.col = (s.col == LAST_COL) ? s.col : s.col + 8'h01;
      end else if (s.arg_contrast) begin
        next_s.arg_contrast = 1'b0;
        next_s.contrast = cmd[5:0];
      end else begin
        // Command decode into registers
        if (cmd[7:4] == CMD_COL_LO) begin
          next_s.col = {s.col[7:4], cmd[3:0]};
        end else if (cmd[7:4] == CMD_COL_HI) begin
          next_s.col = {cmd[3:0], s.col[3:0]};
        end else if (cmd[7:3] == CMD_RATIO) begin
          next_s.ratio = cmd[2:0];
        end else if (cmd[7:3] == CMD_POWER) begin
          next_s.power = cmd[2:0];
        end else if (cmd[7:6] == CMD_START) begin
          next_s.start = cmd[5:0];
        end else if (cmd[7:4] == CMD_PAGE) begin
          next_s.page = (cmd[3:0] > 4'h8) ? 4'h8 : cmd[3:0];
        end else if (cmd == CMD_SEG_NORM || cmd == CMD_SEG_REV) begin
          next_s.seg_rev = cmd[0];
        end else if (cmd == CMD_ROW_NORM || cmd == CMD_ROW_REV) begin
          next_s.row_rev = cmd[3];
        end else if (cmd == CMD_CONTRAST) begin
          next_s.arg_contrast = 1'b1;
        end
      end
    end
    // Regulator source strap: ratio applies only with internal feedback
    next_s.fb_meta = regulator_source_select;
    next_s.int_fb = s.fb_meta;
    // Scan mapping: row remap, start line wrap, non-select beyond mux
    idx = s.row_rev ? (MUX_RATIO - 7'h01 - scan_row) : scan_row;
    next_s.non_sel = scan_row >= MUX_RATIO;
    next_s.row_line = {1'b0, idx[5:0] + s.start};
  end
  // ------------------------------------------------------------
  // Memory addresses
  // ------------------------------------------------------------
  assign ram_addr = 11'(s.page * RAM_COLS) + {3'h0, s.col};
  assign scan_addr = 11'({s.row_line[5:3]} * RAM_COLS)
    + (s.seg_rev ? 11'(LAST_COL - scan_col) : {3'h0, scan_col});
  // Display memory with host and scan ports
  always_ff @(posedge ref_clk) begin
    if (ram_we) begin
      ram[ram_addr] <= fifo_out_data[7:0];
    end
    ram_q <= ram[ram_addr];
    scan_q <= ram[scan_addr];
  end
  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s <= '0;
      s.meta.chip_select_active_low <= 1'b1;
      s.sync.chip_select_active_low <= 1'b1;
      s.prev.chip_select_active_low <= 1'b1;
      s.start <= START_RST;
      s.contrast <= CONTRAST_RST;
      s.ratio <= RATIO_RST;
      s.power <= POWER_RST;
      s.doe_n <= 1'b1;
      scan_byte <= 8'h00;
    end else begin
      s <= next_s;
      scan_byte <= scan_q;
    end
  end
  // Outputs straight from flops
  assign bus.dev_d_out = s.dout;
  assign bus.dev_d_oe_n = s.doe_n;
  assign start_line = s.start;
  assign seg_remap = s.seg_rev;
  assign row_remap = s.row_rev;
  assign contrast = s.contrast;
  assign ratio = s.ratio;
  assign internal_feedback = s.int_fb;
  assign power_ctrl = s.power;
  assign row_driver_output = s.row_line;
  assign row_non_select = s.non_sel;
endmodule : lcd_device_end
`default_nettype wire

// >>> hdl/lcd_host_end.sv
/*
  Host end: turns one request at a time into a 6800, 8080 or serial
  bus cycle with strobe phases from a ref_clk divider.
  Assumes the device end is joined through lcd_bus_if.
*/
`timescale 1ns/1ns
`default_nettype none
module lcd_host_end
  import lcd_host_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  lcd_bus_if.host bus,
  input wire logic [1:0] bus_mode,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_read,
  input wire logic req_dc,
  input wire logic [7:0] req_data,
  output logic rsp_valid,
  output logic [7:0] rsp_data
);
  typedef enum logic [2:0] {IDLE, SETUP, STROBE, HOLD, SER_LO, SER_HI} phase_type;
  typedef struct packed {
    phase_type st;
    logic [7:0] div; // Phase divider
    logic [2:0] bitn; // Serial bit index
    logic [7:0] sh; // Serial byte, MSB out first
    logic rd;
    logic [7:0] meta; // Data sync stage one
    logic [7:0] sync; // Data sync stage two
    logic [1:0] mode;
    logic dc, rw, e, cs_lo, cs_hi;
    logic [7:0] dout;
    logic doe_n;
    logic ready, rv;
    logic [7:0] rdata;
  } host_state_type;
  host_state_type s, next_s;
  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    logic tick;
    next_s = s;
    tick = s.div == HOST_DIV - 8'h01;
    next_s.meta = bus.d;
    next_s.sync = s.meta;
    next_s.rv = 1'b0;
    next_s.div = (tick || s.st == IDLE) ? 8'h00 : s.div + 8'h01;
    unique case (s.st)
      IDLE: begin
        next_s.mode = bus_mode;
        // Strobe rests at its idle level for the pinned mode
        next_s.e = (s.mode == MODE_8080);
        if (req_valid && s.ready) begin
          // Take request, select device, set direction
          next_s.ready = 1'b0;
          next_s.rd = req_read;
          next_s.sh = req_data;
          next_s.dc = req_dc;
          next_s.cs_lo = 1'b0;
          next_s.cs_hi = 1'b1;
          next_s.bitn = 3'h0;
          if (s.mode == MODE_SERIAL) begin
            next_s.doe_n = 1'b0;
            next_s.dout = 8'h00;
            next_s.st = SER_LO;
          end else begin
            next_s.rw = (s.mode == MODE_6800) ? req_read : 1'b1;
            next_s.doe_n = req_read;
            next_s.dout = req_data;
            next_s.st = SETUP;
          end
        end
      end
      SETUP: begin
        if (tick) begin
          // Assert strobe for the selected mode
          if (s.mode == MODE_6800) begin
            next_s.e = 1'b1;
          end else if (s.rd) begin
            next_s.e = 1'b0;
          end else begin
            next_s.rw = 1'b0;
          end
          next_s.st = STROBE;
        end
      end
      STROBE: begin
        if (tick) begin
          // Sample read data, close strobe; data held through HOLD
          next_s.rdata = s.sync;
          next_s.e = (s.mode == MODE_8080);
          next_s.rw = (s.mode == MODE_8080) ? 1'b1 : s.rw;
          next_s.st = HOLD;
        end
      end
      SER_LO: begin
        next_s.dout[SDATA_BIT] = s.sh[7];
        if (tick) begin
          next_s.dout[SCLK_BIT] = 1'b1;
          next_s.st = SER_HI;
        end
      end
      SER_HI: begin
        if (tick) begin
          next_s.dout[SCLK_BIT] = 1'b0;
          next_s.sh = {s.sh[6:0], 1'b0};
          next_s.bitn = s.bitn + 3'h1;
          next_s.st = (s.bitn == 3'h7) ? HOLD : SER_LO;
        end
      end
      HOLD: begin
        if (tick) begin
          // Deselect, release data, answer reads
          next_s.cs_lo = 1'b1;
          next_s.cs_hi = 1'b0;
          next_s.doe_n = 1'b1;
          next_s.rw = 1'b1;
          next_s.rv = s.rd;
          next_s.ready = 1'b1;
          // New mode reaches the pins only while deselected
          next_s.mode = bus_mode;
          next_s.st = IDLE;
        end
      end
      default: begin
        next_s.st = IDLE;
      end
    endcase
  end
  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s <= '0;
      s.st <= IDLE;
      s.rw <= 1'b1;
      s.cs_lo <= 1'b1;
      s.doe_n <= 1'b1;
      s.ready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end
  // Outputs straight from flops
  assign bus.mode = s.mode;
  assign bus.data_select = s.dc;
  assign bus.rw_strobe = s.rw;
  assign bus.rd_strobe = s.e;
  assign bus.chip_select_active_low = s.cs_lo;
  assign bus.chip_select_active_high = s.cs_hi;
  assign bus.host_d_out = s.dout;
  assign bus.host_d_oe_n = s.doe_n;
  assign req_ready = s.ready;
  assign rsp_valid = s.rv;
  assign rsp_data = s.rdata;
endmodule : lcd_host_end
`default_nettype wire

// >>> verif/lcd_bus_props.sv
/* Bus rule checker for the host/display link.
   Assumes the bench wires it beside the joining interface. */
`timescale 1ns/1ns
`default_nettype none
module lcd_bus_props
  import lcd_host_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [1:0] mode,
  input wire logic rw_strobe,
  input wire logic rd_strobe,
  input wire logic chip_select_active_low,
  input wire logic chip_select_active_high,
  input wire logic host_d_oe_n,
  input wire logic dev_d_oe_n,
  input wire logic [7:0] d
);
  // Both chip selects met
  wire sel = !chip_select_active_low && chip_select_active_high;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  deselect_release_a: assert property (!sel [*6] |-> dev_d_oe_n)
    else $error("device drives while deselected");
  no_contention_a: assert property (!(!host_d_oe_n && !dev_d_oe_n))
    else $error("both ends drive the data bus");
  drive_on_read_a: assert property ($fell(dev_d_oe_n) && mode != MODE_SERIAL |->
    ((mode == MODE_8080) ? !rd_strobe : (rw_strobe && rd_strobe)))
    else $error("device drives outside a read");
  write_hold_a: assert property ($rose(rd_strobe) && !rw_strobe && mode == MODE_6800
    |-> ##1 ($stable(d)) [*7]) else $error("write data moves under enable");
  enable_width_a: assert property ($rose(rd_strobe) && mode == MODE_6800
    |-> rd_strobe [*8] ##1 !rd_strobe) else $error("enable width wrong");
  wr_selected_a: assert property ($fell(rw_strobe) && mode == MODE_8080 |-> sel)
    else $error("write strobe while deselected");
  sclk_selected_a: assert property ($rose(d[SCLK_BIT]) && !host_d_oe_n
    && mode == MODE_SERIAL |-> sel) else $error("serial clock while deselected");
  mode_stable_a: assert property (sel |-> $stable(mode))
    else $error("mode moves in a transfer");
  // Main scenarios reached
  cover property ($rose(rd_strobe) && !rw_strobe && mode == MODE_6800);
  cover property ($fell(dev_d_oe_n) && mode == MODE_8080);
  cover property ($rose(d[SCLK_BIT]) && sel && mode == MODE_SERIAL);
endmodule : lcd_bus_props
`default_nettype wire

// >>> verif/lcd_host_interface_decoder_test.sv
/* Testbench joining host end and display end across the interface.
   Assumes the package constants and default mux ratio of 64. */
`timescale 1ns/1ns
`default_nettype none
module lcd_host_interface_decoder_test
  import lcd_host_pkg::*;
;
  logic ref_clk = 0, srst = 1, req_valid = 0, req_read = 0, req_dc = 0;
  logic regulator_source_select = 0, req_ready, rsp_valid, seg_remap, row_remap;
  logic internal_feedback, row_non_select;
  logic [1:0] bus_mode = MODE_6800;
  logic [7:0] req_data = 8'h00, scan_col = 8'h00, rsp_data, scan_byte;
  logic [6:0] scan_row = 7'h00, row_driver_output;
  logic [5:0] start_line, contrast;
  logic [2:0] ratio, power_ctrl;
  int n_mismatch = 0, cmp_count = 0;
  logic [31:0] rng = 32'h00015C72, r; // Xorshift state
  logic [8:0] exp_q[$], e; // Bit 8 marks a dummy read
  logic [7:0] dat [3];
  lcd_bus_if i_lcd_bus_if ();
  lcd_host_end i_lcd_host_end (.ref_clk(ref_clk), .srst(srst), .bus(i_lcd_bus_if),
    .bus_mode(bus_mode), .req_valid(req_valid), .req_ready(req_ready),
    .req_read(req_read), .req_dc(req_dc), .req_data(req_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  lcd_device_end i_lcd_device_end (.ref_clk(ref_clk), .srst(srst), .bus(i_lcd_bus_if),
    .regulator_source_select(regulator_source_select), .scan_row(scan_row),
    .scan_col(scan_col), .start_line(start_line), .seg_remap(seg_remap),
    .row_remap(row_remap), .contrast(contrast), .ratio(ratio),
    .internal_feedback(internal_feedback), .power_ctrl(power_ctrl),
    .row_driver_output(row_driver_output), .row_non_select(row_non_select),
    .scan_byte(scan_byte));
  lcd_bus_props i_lcd_bus_props (.ref_clk(ref_clk), .srst(srst),
    .mode(i_lcd_bus_if.mode), .rw_strobe(i_lcd_bus_if.rw_strobe),
    .rd_strobe(i_lcd_bus_if.rd_strobe), .d(i_lcd_bus_if.d),
    .chip_select_active_low(i_lcd_bus_if.chip_select_active_low),
    .chip_select_active_high(i_lcd_bus_if.chip_select_active_high),
    .host_d_oe_n(i_lcd_bus_if.host_d_oe_n), .dev_d_oe_n(i_lcd_bus_if.dev_d_oe_n));
  // 100 MHz clock
  initial forever #5 ref_clk = ~ref_clk;
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : rnd
  task automatic test_done();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // Bounded wait for the host end to go idle; a hang ends the run
  task automatic wready();
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (n == 400) begin
      n_mismatch++;
      test_done();
    end
  endtask : wready
  // One request, held until the edge that takes it
  task automatic xfer(input logic rd, input logic dc, input logic [7:0] b);
    wready();
    req_valid = 1;
    req_read = rd;
    req_dc = dc;
    req_data = b;
    @(posedge ref_clk);
    #1 req_valid = 0;
  endtask : xfer
  task automatic cmd(input logic [7:0] b);
    xfer(1'b0, 1'b0, b);
  endtask : cmd
  // Idle plus margin for device config to land
  task automatic idle();
    wready();
    repeat (10) @(posedge ref_clk);
    #1;
  endtask : idle
  // Read results checked against the oldest note
  initial forever begin
    @(posedge ref_clk);
    #1;
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) n_mismatch++;
      else e = exp_q.pop_front();
      if (!e[8]) cmp(rsp_data, e[7:0]);
    end
  end
  // ----------------------------------------
  // Main sequence: every bus mode in turn
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    #1 srst = 0;
    for (int m = 0; m < 3; m++) begin
      bus_mode = m[1:0];
      r = rnd();
      regulator_source_select = r[31];
      cmd({CMD_START, r[5:0]});
      cmd(CMD_CONTRAST);
      cmd({2'h0, r[11:6]});
      cmd({CMD_RATIO, r[14:12]});
      cmd({CMD_POWER, r[17:15]});
      cmd(r[18] ? CMD_SEG_REV : CMD_SEG_NORM);
      cmd(r[19] ? CMD_ROW_REV : CMD_ROW_NORM);
      idle();
      cmp({2'h0, start_line}, {2'h0, r[5:0]});
      cmp({2'h0, contrast}, {2'h0, r[11:6]});
      cmp({5'h00, ratio}, {5'h00, r[14:12]});
      cmp({5'h00, power_ctrl}, {5'h00, r[17:15]});
      cmp({6'h00, seg_remap, row_remap}, {6'h00, r[18], r[19]});
      cmp({7'h00, internal_feedback}, {7'h00, r[31]});
      for (int p = 0; p < 2; p++) begin
        cmd(8'hB0);
        cmd(8'h10);
        cmd(8'h00);
        // Moving the address makes the next data read a dummy
        if (p == 1 && m != 2) begin
          exp_q.push_back(9'h100);
          xfer(1'b1, 1'b1, 8'h00);
        end
        for (int k = 0; k < 3; k++) begin
          if (p == 0) dat[k] = 8'(rnd());
          if (p == 0) xfer(1'b0, 1'b1, dat[k]);
          else if (m != 2) exp_q.push_back({1'b0, dat[k]});
          if (p == 1 && m != 2) xfer(1'b1, 1'b1, 8'h00);
        end
        if (p == 0 && m != 2) begin
          exp_q.push_back({2'h0, r[18], r[19], r[31], 4'h0});
          xfer(1'b1, 1'b0, 8'h00);
        end
      end
    end
    // Scroll, non-select rows and scan readout
    cmd(CMD_ROW_NORM);
    cmd(CMD_SEG_NORM);
    scan_row = 7'h10;
    idle();
    cmp({1'b0, row_driver_output}, {2'h0, 6'h10 + r[5:0]});
    cmp({7'h00, row_non_select}, 8'h00);
    scan_row = 7'h46;
    idle();
    cmp({7'h00, row_non_select}, 8'h01);
    cmd({CMD_START, 6'h00});
    scan_row = 7'h00;
    idle();
    cmp(scan_byte, dat[0]);
    // Reversed columns fetch the same byte from the far end
    cmd(CMD_SEG_REV);
    scan_col = LAST_COL;
    idle();
    cmp(scan_byte, dat[0]);
    // Second reset mid-run cuts a serial byte after three bits
    cmd({CMD_START, 6'h2A});
    cmd({CMD_START, 6'h3F});
    repeat (50) @(posedge ref_clk);
    #1 srst = 1;
    repeat (2) @(posedge ref_clk);
    #1 srst = 0;
    idle();
    cmp({2'h0, start_line}, {2'h0, START_RST});
    cmp({2'h0, contrast}, {2'h0, CONTRAST_RST});
    cmp({5'h00, ratio}, {5'h00, RATIO_RST});
    // Stale bits would misalign this byte
    cmd({CMD_START, 6'h15});
    idle();
    cmp({2'h0, start_line}, 8'h15);
    if (exp_q.size() != 0) n_mismatch++;
    test_done();
  end
endmodule : lcd_host_interface_decoder_test
`default_nettype wire
